// ===== hw/adc_seq_params.svh
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL_STS 8'h00
`define OFS_SEQ_FEEDBACK 8'h04
`define OFS_INS_CH_SEL 8'h08
`define OFS_INS_SEQ_SEL 8'h0c
`define OFS_TIME_LIMIT 8'h10
`define OFS_MODE_CTRL 8'h18
`define OFS_SQ_FIRST 8'h20
`define OFS_INS_ENABLE 8'h40
`define OFS_TEST_SET 8'hbc

// ----------------------------------------------------------------
// control and status field positions
// ----------------------------------------------------------------
`define BIT_POWER_ON 0
`define BIT_SOOC 1
`define BIT_SOS 2
`define BIT_READY 4
`define BIT_CAL_SIGN 5
`define BIT_EOC 7
`define BIT_SW_CH_LO 8
`define BIT_STARTUP_DIS 18
`define BIT_SW_FORCE 1
`define TEST_SET_MASK 32'h8003_0007
`define REG_RESET 32'h0000_0000

// ----------------------------------------------------------------
// sizes and timing counts
// ----------------------------------------------------------------
`define SEQ_HALVES 12
`define SEQ_WORDS 6
`define SLOT_MSB 4'hb
`define LAST_HALF 4'hb
`define MAX_CHANNEL 4'hc
`define INS_CH_MAX 6'h3f
`define READY_DELAY_CYC 3'h5
`define TIME_LIMIT_W 16

`endif

// ===== hw/adc_seq_pkg.sv
package adc_seq_pkg;
  `include "adc_seq_params.svh"

  // sequencer states, gray along fetch, pick, convert, hold
  typedef enum logic [1:0] {
    S_FETCH = 2'b00,
    S_PICK = 2'b01,
    S_CONV = 2'b11,
    S_HOLD = 2'b10
  } seq_state_e;

  // origin of the measurement now running
  typedef enum logic [1:0] {
    K_SEQ = 2'b00,
    K_INS_CH = 2'b01,
    K_INS_SEQ = 2'b10,
    K_SW = 2'b11
  } meas_kind_e;

  // what put the block into software mode
  typedef enum logic [1:0] {
    C_FORCE = 2'b00,
    C_SQ_ZERO = 2'b01,
    C_INS_SEQ = 2'b10,
    C_SUSPEND = 2'b11
  } sw_cause_e;

  typedef struct packed {
    seq_state_e st;
    meas_kind_e kind;
    logic cal_busy;
    logic [3:0] ptr;
    logic [3:0] bit_pos;
    logic [5:0] ins_cnt;
    logic ins_seq_pend;
    logic ins_seq_act;
    logic [3:0] ins_seq_pos;
    logic software_mode_force;
    sw_cause_e cause;
    logic [3:0] cause_idx;
    logic [`TIME_LIMIT_W-1:0] timer;
    logic [`TIME_LIMIT_W-1:0] time_limit;
    logic power_on;
    logic startup_dis;
    logic [3:0] software_channel_select;
    logic sos;
    logic sooc;
    logic [3:0] sos_ch;
    logic eoc;
    logic cal_sign;
    logic [2:0] rdy_cnt;
    logic ready;
    logic sw_force;
    logic [1:0] ins_en;
    logic [3:0] ins_ch_sel;
    logic [11:0] ins_seq_sel;
    logic [31:0] test_set;
    logic conv_start;
    logic [3:0] conv_ch;
    logic cal_start;
    logic seq_done;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic evt_ch_s1;
    logic evt_ch_s2;
    logic evt_ch_d;
    logic evt_seq_s1;
    logic evt_seq_s2;
    logic evt_seq_d;
    logic susp_s1;
    logic susp_s2;
    logic susp_d;
  } ctl_state_s;
endpackage

// ===== hw/seq_slot_mem.sv
`timescale 1ns/1ps
// holds the six sequence words, each two 12-bit halves
module seq_slot_mem (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // write port
  input wire logic wr_en,
  input wire logic [2:0] wr_addr,
  input wire logic [23:0] wr_data,
  // registered read ports
  input wire logic [2:0] rd_a_addr,
  output logic [23:0] rd_a_data,
  input wire logic [2:0] rd_b_addr,
  output logic [23:0] rd_b_data
);
  logic [23:0] mem_reg [0:5];

  // one write port, two registered reads; out-of-range reads give zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 6; i++) begin
        mem_reg[i] <= 24'h000000;
      end
      rd_a_data <= 24'h000000;
      rd_b_data <= 24'h000000;
    end else begin
      if (wr_en && wr_addr < 3'h6) begin
        mem_reg[wr_addr] <= wr_data;
      end
      rd_a_data <= (rd_a_addr < 3'h6) ? mem_reg[rd_a_addr] : 24'h000000;
      rd_b_data <= (rd_b_addr < 3'h6) ? mem_reg[rd_b_addr] : 24'h000000;
    end
  end
endmodule

// ===== hw/adc_sequencer_mode_control.sv
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "adc_seq_params.svh"
// What this block does
// - single inserted channel after current, then resume
// - up to 63 queued inserted channel events
// - inserted sequence after current, then resume
// - pulse when inserted sequence has finished
// - software mode: no sequencing, events ignored
// - sequencer default; zero half or force enters
// - zero inserted sequence or suspend also enters
// - software mode visible in feedback register
// - time limit or nonzero inserted sequence leaves
// - nonzero causing half or suspend end leaves
// - start bit converts, reads one until done
// - start bits writable only in software mode
// - end flag bit 7, cleared by read/start
// - channel codes above twelve mean twelve
// - channel written with start not used yet
// - calibration start bit cleared when done
// - power bit; ready five cycles after enable
// - suspend stops after conversion, resumes next
// - suspend keeps software starts, no limit
// - bit 18 suppresses postprocessing start-up
// - walk halves in order, msb first, skip zeros
module adc_sequencer_mode_control
  import adc_seq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // hardware events and debug, asynchronous pins
  input wire logic evt_inserted_channel,
  input wire logic evt_inserted_sequence,
  input wire logic debug_suspend,
  // converter core
  input wire logic conv_done,
  input wire logic cal_done,
  input wire logic cal_comparator,
  output logic conv_start,
  output logic [3:0] conv_channel,
  output logic cal_start,
  output logic converter_power_on,
  output logic postproc_startup_disable,
  output logic [31:0] test_settings,
  // status
  output logic inserted_sequence_done,
  output logic software_mode_active
);
  import adc_seq_pkg::*;

  ctl_state_s s_reg;
  ctl_state_s s_next;
  logic [23:0] slot_word;
  logic [23:0] bus_word;
  logic mem_wr;

  // ----------------------------------------------------------------
  // channel code map
  // ----------------------------------------------------------------
  function automatic logic [3:0] map_ch(input logic [3:0] code);
    map_ch = (code > `MAX_CHANNEL) ? `MAX_CHANNEL : code;
  endfunction

  // ----------------------------------------------------------------
  // sequence memory
  // ----------------------------------------------------------------
  assign mem_wr = psel && penable && s_reg.pready && pwrite &&
                  paddr[7:5] == 3'h1 && paddr[1:0] == 2'h0;

  seq_slot_mem u_mem (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(mem_wr),
    .wr_addr(paddr[4:2]),
    .wr_data({pwdata[27:16], pwdata[11:0]}),
    .rd_a_addr(s_reg.ptr[3:1]),
    .rd_a_data(slot_word),
    .rd_b_addr(paddr[4:2]),
    .rd_b_data(bus_word)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic acc_wr;
    logic acc_rd;
    logic is_sq;
    logic enter;
    logic leave;
    logic ev_ch;
    logic ev_seq;
    logic susp;
    logic [11:0] half;
    logic [31:0] rd;
    sw_cause_e new_cause;
    logic [3:0] new_idx;
    acc_wr = psel && penable && s_reg.pready && pwrite;
    acc_rd = psel && penable && s_reg.pready && !pwrite;
    is_sq = paddr[7:5] == 3'h1 && paddr[4:2] < 3'h6;
    enter = 1'b0;
    leave = 1'b0;
    new_cause = C_FORCE;
    new_idx = 4'h0;
    rd = 32'h0000_0000;
    half = s_reg.ptr[0] ? slot_word[23:12] : slot_word[11:0];
    s_next = s_reg;
    s_next.conv_start = 1'b0;
    s_next.cal_start = 1'b0;
    s_next.seq_done = 1'b0;
    s_next.cal_sign = cal_comparator;
    // two-flop synchronisers, a third flop for edge detection
    s_next.evt_ch_s1 = evt_inserted_channel;
    s_next.evt_ch_s2 = s_reg.evt_ch_s1;
    s_next.evt_ch_d = s_reg.evt_ch_s2;
    s_next.evt_seq_s1 = evt_inserted_sequence;
    s_next.evt_seq_s2 = s_reg.evt_seq_s1;
    s_next.evt_seq_d = s_reg.evt_seq_s2;
    s_next.susp_s1 = debug_suspend;
    s_next.susp_s2 = s_reg.susp_s1;
    s_next.susp_d = s_reg.susp_s2;
    ev_ch = s_reg.evt_ch_s2 && !s_reg.evt_ch_d;
    ev_seq = s_reg.evt_seq_s2 && !s_reg.evt_seq_d;
    susp = s_reg.susp_s2;

    // bus answer: pready one access cycle late so the memory read settles
    s_next.pready = psel && penable && !s_reg.pready;
    s_next.pslverr = 1'b0;
    if (psel && penable && !s_reg.pready) begin
      case (paddr)
        `OFS_CTRL_STS: begin
          rd[`BIT_STARTUP_DIS] = s_reg.startup_dis;
          rd[11:8] = s_reg.software_channel_select;
          rd[`BIT_EOC] = s_reg.eoc;
          rd[`BIT_CAL_SIGN] = s_reg.cal_sign;
          rd[`BIT_READY] = s_reg.ready;
          rd[`BIT_SOS] = s_reg.sos;
          rd[`BIT_SOOC] = s_reg.sooc;
          rd[`BIT_POWER_ON] = s_reg.power_on;
        end
        `OFS_SEQ_FEEDBACK: begin
          rd[0] = s_reg.software_mode_force;
          rd[2:1] = s_reg.cause;
          rd[7:4] = s_reg.cause_idx;
          rd[11:8] = s_reg.ptr;
          rd[15:12] = s_reg.bit_pos;
          rd[21:16] = s_reg.ins_cnt;
          rd[22] = s_reg.ins_seq_act;
        end
        `OFS_INS_CH_SEL: rd[3:0] = s_reg.ins_ch_sel;
        `OFS_INS_SEQ_SEL: rd[11:0] = s_reg.ins_seq_sel;
        `OFS_TIME_LIMIT: rd[`TIME_LIMIT_W-1:0] = s_reg.time_limit;
        `OFS_MODE_CTRL: rd[`BIT_SW_FORCE] = s_reg.sw_force;
        `OFS_INS_ENABLE: rd[1:0] = s_reg.ins_en;
        `OFS_TEST_SET: rd = s_reg.test_set;
        default: begin
          if (is_sq && paddr[1:0] == 2'h0) begin
            rd = {4'h0, bus_word[23:12], 4'h0, bus_word[11:0]};
          end else if (!pwrite) begin
            s_next.pslverr = 1'b1;
          end
        end
      endcase
      s_next.prdata = rd;
    end

    // reading the control word clears the end flag
    if (acc_rd && paddr == `OFS_CTRL_STS) begin
      s_next.eoc = 1'b0;
    end

    // register writes and the mode triggers they carry
    if (acc_wr) begin
      case (paddr)
        `OFS_CTRL_STS: begin
          s_next.power_on = pwdata[`BIT_POWER_ON];
          s_next.startup_dis = pwdata[`BIT_STARTUP_DIS];
          s_next.software_channel_select = pwdata[11:8];
          if (s_reg.software_mode_force && pwdata[`BIT_SOS] && !s_reg.sos) begin
            s_next.sos = 1'b1;
            s_next.sos_ch = map_ch(s_reg.software_channel_select);
            s_next.eoc = 1'b0;
          end
          if (s_reg.software_mode_force && pwdata[`BIT_SOOC]) begin
            s_next.sooc = 1'b1;
          end
        end
        `OFS_MODE_CTRL: begin
          s_next.sw_force = pwdata[`BIT_SW_FORCE];
          if (pwdata[`BIT_SW_FORCE] && !s_reg.sw_force) begin
            enter = 1'b1;
            new_cause = C_FORCE;
          end else if (!pwdata[`BIT_SW_FORCE] &&
                       s_reg.cause == C_FORCE && !susp) begin
            leave = 1'b1;
          end
        end
        `OFS_INS_CH_SEL: s_next.ins_ch_sel = pwdata[3:0];
        `OFS_INS_SEQ_SEL: begin
          s_next.ins_seq_sel = pwdata[11:0];
          if (pwdata[11:0] == 12'h000 && s_reg.ins_en[1]) begin
            enter = 1'b1;
            new_cause = C_INS_SEQ;
          end else if (pwdata[11:0] != 12'h000 && !susp) begin
            leave = 1'b1;
          end
        end
        `OFS_TIME_LIMIT: s_next.time_limit = pwdata[`TIME_LIMIT_W-1:0];
        `OFS_INS_ENABLE: s_next.ins_en = pwdata[1:0];
        `OFS_TEST_SET: s_next.test_set = pwdata & `TEST_SET_MASK;
        default: begin
          if (mem_wr && is_sq) begin
            if (pwdata[11:0] == 12'h000) begin
              enter = 1'b1;
              new_cause = C_SQ_ZERO;
              new_idx = {paddr[4:2], 1'b0};
            end else if (pwdata[27:16] == 12'h000) begin
              enter = 1'b1;
              new_cause = C_SQ_ZERO;
              new_idx = {paddr[4:2], 1'b1};
            end else if (s_reg.cause == C_SQ_ZERO && !susp &&
                         s_reg.cause_idx[3:1] == paddr[4:2]) begin
              leave = 1'b1;
            end
          end
        end
      endcase
    end

    // suspend edges and the time limit
    if (susp && !s_reg.susp_d) begin
      enter = 1'b1;
      new_cause = C_SUSPEND;
    end else if (!susp && s_reg.susp_d) begin
      leave = 1'b1;
    end
    // a limit of zero means no limit; suspend stops the clock on it
    if (s_reg.software_mode_force && !susp && s_reg.time_limit != '0) begin
      s_next.timer = s_reg.timer + 1'b1;
      if (s_reg.timer >= s_reg.time_limit - 1'b1) begin
        leave = 1'b1;
      end
    end
    if (enter) begin
      s_next.software_mode_force = 1'b1;
      s_next.cause = new_cause;
      s_next.cause_idx = new_idx;
      s_next.timer = '0;
    end else if (leave && s_reg.software_mode_force) begin
      s_next.software_mode_force = 1'b0;
      s_next.timer = '0;
    end

    // converter ready after five cycles of power
    if (!s_reg.power_on) begin
      s_next.rdy_cnt = 3'h0;
      s_next.ready = 1'b0;
    end else if (!s_reg.ready) begin
      s_next.rdy_cnt = s_reg.rdy_cnt + 3'h1;
      s_next.ready = s_reg.rdy_cnt == `READY_DELAY_CYC - 3'h1;
    end

    // sequencer
    case (s_reg.st)
      S_FETCH: begin
        s_next.st = s_reg.software_mode_force ? S_HOLD : S_PICK;
      end
      S_PICK: begin
        if (s_reg.software_mode_force) begin
          s_next.st = S_HOLD;
        end else if (s_reg.ins_cnt != 6'h00) begin
          s_next.ins_cnt = s_reg.ins_cnt - 6'h01;
          s_next.kind = K_INS_CH;
          s_next.conv_ch = map_ch(s_reg.ins_ch_sel);
          s_next.conv_start = 1'b1;
          s_next.st = S_CONV;
        end else if (s_reg.ins_seq_act) begin
          s_next.ins_seq_pos = s_reg.ins_seq_pos - 4'h1;
          s_next.ins_seq_act = s_reg.ins_seq_pos != 4'h0;
          if (s_reg.ins_seq_sel[s_reg.ins_seq_pos]) begin
            s_next.kind = K_INS_SEQ;
            s_next.conv_ch = s_reg.ins_seq_pos;
            s_next.conv_start = 1'b1;
            s_next.st = S_CONV;
          end else if (s_reg.ins_seq_pos == 4'h0) begin
            s_next.seq_done = 1'b1;
          end
        end else if (s_reg.ins_seq_pend) begin
          s_next.ins_seq_pend = 1'b0;
          s_next.ins_seq_act = 1'b1;
          s_next.ins_seq_pos = `SLOT_MSB;
        end else begin
          // the slot pointer moves on before the measurement runs
          s_next.bit_pos = s_reg.bit_pos - 4'h1;
          if (s_reg.bit_pos == 4'h0) begin
            s_next.bit_pos = `SLOT_MSB;
            s_next.ptr = (s_reg.ptr == `LAST_HALF) ? 4'h0 : s_reg.ptr + 4'h1;
            s_next.st = S_FETCH;
          end
          if (half[s_reg.bit_pos]) begin
            s_next.kind = K_SEQ;
            s_next.conv_ch = s_reg.bit_pos;
            s_next.conv_start = 1'b1;
            s_next.st = S_CONV;
          end
        end
      end
      S_CONV: begin
        if (s_reg.cal_busy ? cal_done : conv_done) begin
          if (s_reg.cal_busy) begin
            s_next.sooc = 1'b0;
            s_next.cal_busy = 1'b0;
          end else if (s_reg.kind == K_SW) begin
            s_next.sos = 1'b0;
            s_next.eoc = 1'b1;
          end else if (s_reg.kind == K_INS_SEQ && !s_reg.ins_seq_act) begin
            s_next.seq_done = 1'b1;
          end
          s_next.st = s_reg.software_mode_force ? S_HOLD : S_FETCH;
        end
      end
      S_HOLD: begin
        if (!s_reg.software_mode_force) begin
          s_next.st = S_FETCH;
        end else if (s_reg.sos) begin
          s_next.kind = K_SW;
          s_next.conv_ch = s_reg.sos_ch;
          s_next.conv_start = 1'b1;
          s_next.st = S_CONV;
        end else if (s_reg.sooc) begin
          s_next.cal_busy = 1'b1;
          s_next.cal_start = 1'b1;
          s_next.st = S_CONV;
        end
      end
      default: s_next.st = S_FETCH;
    endcase

    // events only count outside software mode and suspend; placed after
    // the sequencer so a new request beats the clear of the old one
    if (!s_reg.software_mode_force && !susp) begin
      if (ev_seq && s_reg.ins_en[1]) begin
        s_next.ins_seq_pend = 1'b1;
      end
    end

    // inserted channel events queue up to the saturation count
    if (!s_reg.software_mode_force && !susp && ev_ch && s_reg.ins_en[0] &&
        s_next.ins_cnt != `INS_CH_MAX) begin
      s_next.ins_cnt = s_next.ins_cnt + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.bit_pos <= `SLOT_MSB;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign conv_start = s_reg.conv_start;
  assign conv_channel = s_reg.conv_ch;
  assign cal_start = s_reg.cal_start;
  assign converter_power_on = s_reg.power_on;
  assign postproc_startup_disable = s_reg.startup_dis;
  assign test_settings = s_reg.test_set;
  assign inserted_sequence_done = s_reg.seq_done;
  assign software_mode_active = s_reg.software_mode_force;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  start_gated_a: assert property (
    (mem_wr == 1'b0 && psel && penable && pready && pwrite &&
     paddr == `OFS_CTRL_STS && !s_reg.software_mode_force && !s_reg.sos)
    |=> !s_reg.sos)
    else $error("start bit accepted outside software mode");
  eoc_after_sw_a: assert property (
    (s_reg.st == S_CONV && s_reg.kind == K_SW && !s_reg.cal_busy &&
     conv_done) |=> (s_reg.eoc && !s_reg.sos))
    else $error("end flag not set after software conversion");
  ready_delay_a: assert property (
    $rose(s_reg.power_on) |-> !s_reg.ready [*5] ##1 s_reg.ready)
    else $error("ready not five cycles after power on");
  channel_range_a: assert property (
    conv_start |-> conv_channel <= `MAX_CHANNEL)
    else $error("conversion channel above twelve");
  sw_no_seq_a: assert property (
    (conv_start && s_reg.software_mode_force && $past(s_reg.software_mode_force))
    |-> s_reg.kind == K_SW)
    else $error("sequenced conversion in software mode");
  suspend_entry_a: assert property (
    (s_reg.susp_s2 && !s_reg.susp_d) |=> s_reg.software_mode_force [*2])
    else $error("suspend did not enter software mode");
  limit_exit_a: assert property (
    (s_reg.software_mode_force && !s_reg.susp_s2 && s_reg.time_limit != '0 &&
     s_reg.timer == s_reg.time_limit - 1'b1)
    |=> !s_reg.software_mode_force || s_reg.timer == '0)
    else $error("time limit did not end software mode");
  events_ignored_a: assert property (
    (s_reg.susp_s2 && s_reg.susp_d) |=> s_reg.ins_cnt <= $past(s_reg.ins_cnt))
    else $error("inserted event counted during suspend");
  seq_done_cause_a: assert property (
    inserted_sequence_done |-> !s_reg.ins_seq_act && $past(s_reg.kind) != K_SW)
    else $error("sequence done pulse without inserted sequence");

  ins_ch_c: cover property (conv_start && s_reg.kind == K_INS_CH);
  ins_seq_c: cover property (inserted_sequence_done);
  sw_conv_c: cover property (s_reg.software_mode_force ##[1:200] $rose(s_reg.eoc));
  suspend_c: cover property ($fell(s_reg.susp_s2) ##1 !s_reg.software_mode_force);
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`include "adc_seq_params.svh"
module tb_top;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, rerr;
  logic evt_inserted_channel, evt_inserted_sequence, debug_suspend;
  logic conv_done, cal_done, cal_comparator, conv_start, cal_start;
  logic converter_power_on, postproc_startup_disable;
  logic inserted_sequence_done, software_mode_active;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, test_settings, rdat, d;
  logic [3:0] conv_channel, c, old;
  int error_cnt, n_checks, n, i;
  int ndone = 0;

  adc_sequencer_mode_control dut_u (
    .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .evt_inserted_channel, .evt_inserted_sequence,
    .debug_suspend, .conv_done, .cal_done, .cal_comparator, .conv_start,
    .conv_channel, .cal_start, .converter_power_on,
    .postproc_startup_disable, .test_settings, .inserted_sequence_done,
    .software_mode_active
  );

  // ----
  // clock, pulse counter, watchdog
  // ----
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  // done is a one-cycle pulse, so exactly one edge sees it high
  always @(posedge clk) begin
    if (inserted_sequence_done === 1'b1) ndone <= ndone + 1;
  end

  // whole run is under a thousand cycles; this is far beyond it
  initial begin
    #3000000;
    error_cnt++;
    report_and_stop();
  end

  // ----
  // tasks
  // ----
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // pready is looked at on each rising edge; the request stands until
  // then, and one idle edge keeps psel from being set twice at once
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int k;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk) penable <= 1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (k >= 40) error_cnt++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // core stand-in: checks the channel, optionally fires an event
  // while busy, answers done after a fixed conversion time
  task automatic conv(input logic [3:0] ch, input int ev);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (conv_start !== 1'b1 && k < 200);
    chk(conv_channel, ch);
    @(posedge clk);
    if (ev == 1) evt_inserted_channel <= 1;
    if (ev == 2) evt_inserted_sequence <= 1;
    repeat (2) @(posedge clk);
    evt_inserted_channel <= 0;
    evt_inserted_sequence <= 0;
    repeat (6) @(posedge clk);
    conv_done <= 1;
    @(posedge clk) conv_done <= 0;
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    rst_b = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h00;
    pwdata = 32'h0;
    evt_inserted_channel = 0;
    evt_inserted_sequence = 0;
    debug_suspend = 0;
    conv_done = 0;
    cal_done = 0;
    cal_comparator = 0;
    error_cnt = 0;
    n_checks = 0;
    void'($urandom(31));
    repeat (8) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    rd(8'h00);
    chk(rdat, 32'h0);
    rd(8'hbc);
    chk(rdat, 32'h0);
    rd(8'h44);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    d = $urandom;
    wr(8'hbc, d);
    rd(8'hbc);
    chk(rdat, d & `TEST_SET_MASK);
    chk(test_settings, d & `TEST_SET_MASK);
    $display("test registers done");
    // ready must still be low a few cycles after power-on
    wr(8'h00, 32'h0004_0001);
    rd(8'h00);
    chk(rdat[4], 1'b0);
    repeat (4) @(posedge clk);
    rd(8'h00);
    chk(rdat[4], 1'b1);
    chk({converter_power_on, postproc_startup_disable}, 2'b11);
    wr(8'h00, 32'h5);
    rd(8'h00);
    chk(rdat[2], 1'b0);
    $display("test power done");
    wr(8'h18, 32'h2);
    repeat (4) @(posedge clk);
    chk(software_mode_active, 1'b1);
    rd(8'h04);
    chk(rdat[2:0], 3'h1);
    old = 4'h0;
    for (i = 0; i < 4; i++) begin
      c = (i == 2) ? 4'hf : 4'($urandom);
      fork
        conv((old > 12) ? 4'hc : old, 0);
        begin
          wr(8'h00, {20'h0, c, 8'h05});
          rd(8'h00);
          chk(rdat[7:0], 8'h15);
        end
      join
      repeat (2) @(posedge clk);
      rd(8'h00);
      chk(rdat[7:0], 8'h91);
      rd(8'h00);
      chk(rdat[7], 1'b0);
      old = c;
    end
    cal_comparator <= 1;
    fork
      begin
        n = 0;
        do begin
          @(negedge clk);
          n++;
        end while (cal_start !== 1'b1 && n < 50);
        repeat (6) @(posedge clk);
        cal_done <= 1;
        @(posedge clk) cal_done <= 0;
      end
      begin
        wr(8'h00, 32'h3);
        rd(8'h00);
        chk(rdat[1], 1'b1);
      end
    join
    repeat (2) @(posedge clk);
    rd(8'h00);
    chk(rdat[5:0], 6'h31);
    wr(8'h18, 32'h0);
    repeat (4) @(posedge clk);
    chk(software_mode_active, 1'b0);
    $display("test software mode done");
    wr(8'h10, 32'd20);
    wr(8'h18, 32'h2);
    n = 0;
    while (software_mode_active !== 1'b0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk(n >= 16 && n <= 24, 1'b1);
    @(posedge clk);
    wr(8'h18, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h40, 32'h3);
    debug_suspend <= 1;
    repeat (8) @(posedge clk);
    // an event during suspend must not be queued
    evt_inserted_channel <= 1;
    chk(software_mode_active, 1'b1);
    rd(8'h04);
    chk(rdat[2:0], 3'h7);
    evt_inserted_channel <= 0;
    rd(8'h04);
    chk(rdat[21:16], 32'h0);
    debug_suspend <= 0;
    repeat (8) @(posedge clk);
    chk(software_mode_active, 1'b0);
    $display("test limit and suspend done");
    wr(8'h08, 32'h5);
    wr(8'h0c, 32'h0c0);
    // write the first word while the walk is far from it, so the
    // first slot seen is the top bit of the first half
    n = 0;
    do begin
      rd(8'h04);
      n++;
    end while (rdat[11:8] != 4'h6 && n < 60);
    // both halves nonzero, otherwise software mode would be entered
    wr(8'h20, 32'h0004_0801);
    conv(4'hb, 1);
    conv(4'h5, 0);
    conv(4'h0, 2);
    conv(4'h7, 0);
    conv(4'h6, 0);
    repeat (10) @(posedge clk);
    chk(ndone, 1);
    conv(4'h2, 0);
    conv(4'hb, 0);
    $display("test sequencer done");
    report_and_stop();
  end
endmodule
